/* adc_device.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_device #(
  parameter int POR_CYCLES  = adc_pkg::POR_CYCLES_DFLT,
  parameter int CONV_CYCLES = adc_pkg::CONV_CYCLES_DFLT,
  parameter int TEST_CYCLES = adc_pkg::STATUS_TEST_CYCLES,
  parameter int RES_W       = adc_pkg::RESULT_BITS
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // serial link
  adc_link_if.device            link,
  // conversion result from the converter core
  input  wire logic [RES_W-1:0] i_result,
  // status
  output logic                  o_ext_mode,
  output logic                  o_sleeping,
  output logic                  o_conv_start
);
  import adc_pkg::*;
  localparam int FRAME = RES_W + 1;

  // ****************************************
  // state
  // ****************************************
  dev_state_e           state_q;
  dev_state_e           state_d;
  logic                 ext_q;
  logic                 ext_d;
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     cnt_d;
  logic [BIT_CNT_W-1:0] bits_q;
  logic [BIT_CNT_W-1:0] bits_d;
  logic [FRAME-1:0]     shift_q;
  logic [FRAME-1:0]     shift_d;
  logic                 hold_q;
  logic                 hold_d;
  logic                 pullup_q;
  logic                 pullup_d;
  logic                 cs_prev_q;
  logic                 sck_prev_q;
  logic                 sck_o_q;
  logic                 sck_o_d;
  logic                 sck_oe_q;
  logic                 sck_oe_d;
  logic                 sdo_q;
  logic                 sdo_d;
  logic                 sdo_oe_q;
  logic                 sleep_q;
  logic                 start_q;
  logic                 start_d;
  logic                 go_conv;
  logic                 repull;
  logic                 mode_ext;
  logic                 cs_fall;
  logic                 cs_rise;
  logic                 sck_rise;
  logic                 sck_fall;
  logic                 gen_run;
  logic                 gen_rise;
  logic                 gen_fall;

  // ****************************************
  // internal serial clock
  // ****************************************
  assign gen_run = (state_q == DS_OUTPUT) && !ext_q;

  // conversion clock divided by eight
  sck_gen #(
    .DIV (SCK_DIV)
  ) u_sck_gen (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_run   (gen_run),
    .o_level (),
    .o_rise  (gen_rise),
    .o_fall  (gen_fall)
  );

  // ****************************************
  // pin edge detection
  // ****************************************
  assign cs_fall  = cs_prev_q & !link.cs_n;
  assign cs_rise  = !cs_prev_q & link.cs_n;
  assign sck_rise = link.sck & !sck_prev_q;
  assign sck_fall = !link.sck & sck_prev_q;
  // mode in force this cycle, a select fall reselects it
  assign mode_ext = cs_fall ? !link.sck : ext_q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    ext_d   = mode_ext;
    cnt_d   = cnt_q;
    bits_d  = bits_q;
    shift_d = shift_q;
    hold_d  = hold_q;
    start_d = 1'h0;
    go_conv = 1'h0;
    repull  = 1'h0;
    case (state_q)
      DS_POR: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(POR_CYCLES - 1)) begin
          ext_d   = !link.sck;
          go_conv = 1'h1;
        end
      end
      DS_CONVERT: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cnt_q == CNT_W'(CONV_CYCLES - 1)) begin
          shift_d = {1'h0, i_result};
          cnt_d   = '0;
          if (!link.cs_n && !mode_ext) begin
            state_d = DS_TEST;
          end else begin
            state_d = DS_SLEEP;
          end
        end
      end
      DS_SLEEP: begin
        if (!link.cs_n && mode_ext && sck_rise) begin
          state_d = DS_OUTPUT;
          bits_d  = BIT_CNT_W'(1);
        end else if (!link.cs_n && !mode_ext) begin
          state_d = DS_TEST;
          cnt_d   = '0;
        end
      end
      DS_TEST: begin
        cnt_d = cnt_q + CNT_W'(1);
        if (cs_rise) begin
          state_d = DS_SLEEP;
          repull  = 1'h1;
        end else if (cnt_q == CNT_W'(TEST_CYCLES - 1)) begin
          state_d = DS_OUTPUT;
          bits_d  = '0;
        end
      end
      DS_OUTPUT: begin
        if (cs_rise) begin
          go_conv = 1'h1;
        end else if (ext_q) begin
          if (sck_rise) begin
            bits_d = bits_q + BIT_CNT_W'(1);
          end
          if (sck_fall && bits_q == BIT_CNT_W'(FRAME)) begin
            go_conv = 1'h1;
          end else if (sck_fall) begin
            shift_d = {shift_q[FRAME-2:0], 1'h1};
          end
        end else begin
          if (gen_rise) begin
            bits_d = bits_q + BIT_CNT_W'(1);
          end
          if (bits_q == BIT_CNT_W'(FRAME)) begin // last bit stands through the 19th rise
            go_conv = 1'h1;
            hold_d  = 1'h1;
          end
          if (gen_fall) begin
            shift_d = {shift_q[FRAME-2:0], 1'h1};
          end
        end
      end
      default: begin
        state_d = DS_POR;
      end
    endcase
    if (go_conv) begin
      state_d = DS_CONVERT;
      cnt_d   = '0;
      bits_d  = '0;
      start_d = 1'h1;
    end
    if (link.cs_n || cs_fall) begin
      hold_d = 1'h0;
    end
    // pull-up follows the pin, a low pin switches it off unless select rises in the test state
    pullup_d = link.sck | repull;
    // device drives the clock pin only in internal mode with select low
    sck_oe_d = !link.cs_n && !ext_d && (state_q != DS_POR);
    if (state_d == DS_OUTPUT) begin
      sck_o_d = gen_rise ? 1'h1 : (gen_fall ? 1'h0 : sck_o_q);
    end else begin
      sck_o_d = hold_d;
    end
    // data pin: result bit in output state, else done status
    if (state_d == DS_OUTPUT) begin
      sdo_d = shift_d[FRAME-1];
    end else begin
      sdo_d = (state_d == DS_CONVERT) || (state_d == DS_POR);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q    <= DS_POR;
      ext_q      <= EXT_MODE_RST;
      cnt_q      <= '0;
      bits_q     <= '0;
      shift_q    <= '0;
      hold_q     <= 1'h0;
      pullup_q   <= PULLUP_RST;
      cs_prev_q  <= CS_N_RST;
      sck_prev_q <= 1'h1;
      sck_o_q    <= 1'h0;
      sck_oe_q   <= 1'h0;
      sdo_q      <= 1'h1;
      sdo_oe_q   <= 1'h0;
      sleep_q    <= 1'h0;
      start_q    <= 1'h0;
    end else begin
      state_q    <= state_d;
      ext_q      <= ext_d;
      cnt_q      <= cnt_d;
      bits_q     <= bits_d;
      shift_q    <= shift_d;
      hold_q     <= hold_d;
      pullup_q   <= pullup_d;
      cs_prev_q  <= link.cs_n;
      sck_prev_q <= link.sck;
      sck_o_q    <= sck_o_d;
      sck_oe_q   <= sck_oe_d;
      sdo_q      <= sdo_d;
      sdo_oe_q   <= !link.cs_n;
      sleep_q    <= (state_d == DS_SLEEP);
      start_q    <= start_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.dev_sck_o  = sck_o_q;
  assign link.dev_sck_oe = sck_oe_q;
  assign link.dev_pullup = pullup_q;
  assign link.dev_sdo_o  = sdo_q;
  assign link.dev_sdo_oe = sdo_oe_q;
  assign o_ext_mode      = ext_q;
  assign o_sleeping      = sleep_q;
  assign o_conv_start    = start_q;
endmodule // adc_device
`default_nettype wire

/* adc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_host #(
  parameter int RES_W   = adc_pkg::RESULT_BITS,
  parameter int SCK_DIV = adc_pkg::SCK_DIV
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  // serial link
  adc_link_if.host              link,
  // user request
  input  wire logic             i_ext_mode,
  input  wire logic             i_start,
  // user answer
  output logic                  o_busy,
  output logic [RES_W-1:0]      o_data,
  output logic                  o_valid
);
  import adc_pkg::*;
  localparam int FRAME = RES_W + 1;

  // ****************************************
  // state
  // ****************************************
  host_state_e          state_q;
  host_state_e          state_d;
  logic                 cs_q;
  logic                 cs_d;
  logic                 sck_oe_q;
  logic [BIT_CNT_W-1:0] cnt_q;
  logic [BIT_CNT_W-1:0] cnt_d;
  logic [FRAME-1:0]     cap_q;
  logic [FRAME-1:0]     cap_d;
  logic [RES_W-1:0]     data_q;
  logic [RES_W-1:0]     data_d;
  logic                 valid_q;
  logic                 valid_d;
  logic                 busy_q;
  logic                 sck_prev_q;
  logic                 rise_evt;
  logic                 gen_level;
  logic                 gen_rise;
  logic                 gen_fall;

  // ****************************************
  // external serial clock source
  // ****************************************
  sck_gen #(
    .DIV (SCK_DIV)
  ) u_sck_gen (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_run   ((state_q == HS_XFER) && i_ext_mode),
    .o_level (gen_level),
    .o_rise  (gen_rise),
    .o_fall  (gen_fall)
  );

  // sample strobe: own clock, or rises of the device clock
  assign rise_evt = i_ext_mode ? gen_rise : (link.sck & !sck_prev_q);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    cs_d    = cs_q;
    cnt_d   = cnt_q;
    cap_d   = cap_q;
    data_d  = data_q;
    valid_d = 1'h0;
    case (state_q)
      HS_IDLE: begin
        if (i_start) begin
          cs_d    = 1'h0;
          cnt_d   = '0;
          state_d = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (cnt_q != BIT_CNT_W'(HOST_SETTLE)) begin
          cnt_d = cnt_q + BIT_CNT_W'(1);
        end else if (!link.sdo) begin
          cnt_d   = '0;
          state_d = HS_XFER;
        end
      end
      HS_XFER: begin
        if (rise_evt) begin
          cap_d = {cap_q[FRAME-2:0], link.sdo};
          cnt_d = cnt_q + BIT_CNT_W'(1);
        end
        if (i_ext_mode && gen_fall && cnt_q == BIT_CNT_W'(FRAME)) begin
          state_d = HS_END;
        end else if (!i_ext_mode && rise_evt && cnt_q == BIT_CNT_W'(FRAME - 1)) begin
          state_d = HS_END;
        end
      end
      HS_END: begin
        cs_d    = 1'h1;
        data_d  = cap_q[RES_W-1:0];
        valid_d = 1'h1;
        state_d = HS_IDLE;
      end
      default: begin
        state_d = HS_IDLE;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q    <= HS_IDLE;
      cs_q       <= CS_N_RST;
      sck_oe_q   <= 1'h0;
      cnt_q      <= '0;
      cap_q      <= '0;
      data_q     <= '0;
      valid_q    <= 1'h0;
      busy_q     <= 1'h0;
      sck_prev_q <= 1'h1;
    end else begin
      state_q    <= state_d;
      cs_q       <= cs_d;
      sck_oe_q   <= i_ext_mode;
      cnt_q      <= cnt_d;
      cap_q      <= cap_d;
      data_q     <= data_d;
      valid_q    <= valid_d;
      busy_q     <= (state_d != HS_IDLE);
      sck_prev_q <= link.sck;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign link.cs_n        = cs_q;
  assign link.host_sck_o  = gen_level;
  assign link.host_sck_oe = sck_oe_q;
  assign o_busy           = busy_q;
  assign o_data           = data_q;
  assign o_valid          = valid_q;
endmodule // adc_host
`default_nettype wire

/* adc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  // chip select from the host
  logic cs_n;
  // serial clock drivers and device pull-up
  logic host_sck_o;
  logic host_sck_oe;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_pullup;
  // serial data driver
  logic dev_sdo_o;
  logic dev_sdo_oe;
  // resolved wire levels
  logic sck;
  logic sdo;

  // undriven clock pin follows the weak pull-up, else sits low
  assign sck = dev_sck_oe ? dev_sck_o : (host_sck_oe ? host_sck_o : dev_pullup);
  // undriven data pin reads high
  assign sdo = dev_sdo_oe ? dev_sdo_o : 1'h1;

  modport device (input cs_n, sck, output dev_sck_o, dev_sck_oe, dev_pullup, dev_sdo_o, dev_sdo_oe);
  modport host (output cs_n, host_sck_o, host_sck_oe, input sck, sdo);
endinterface
`default_nettype wire

/* adc_pkg.sv */
`default_nettype none
package adc_pkg;
  // ****************************************
  // clock, frame and timing
  // ****************************************
  localparam int CLK_KHZ              = 25000;
  localparam int RESULT_BITS          = 18;
  localparam int FRAME_BITS           = 19;
  localparam int SCK_DIV              = 8;
  localparam int STATUS_TEST_DELAY_NS = 23000;
  localparam int STATUS_TEST_CYCLES   = (STATUS_TEST_DELAY_NS * CLK_KHZ + 999999) / 1000000;
  localparam int POR_TIME_US          = 1000;
  localparam int POR_CYCLES_DFLT      = (POR_TIME_US * CLK_KHZ) / 1000;
  localparam int CONV_TIME_MS         = 147;
  localparam int CONV_CYCLES_DFLT     = CONV_TIME_MS * CLK_KHZ;
  localparam int CNT_W                = 22;
  localparam int BIT_CNT_W            = 5;
  localparam int HOST_SETTLE          = 3;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic PULLUP_RST   = 1'h1;
  localparam logic EXT_MODE_RST = 1'h0;
  localparam logic CS_N_RST     = 1'h1;
  // ****************************************
  // state types
  // ****************************************
  typedef enum logic [2:0] {DS_POR, DS_CONVERT, DS_SLEEP, DS_TEST, DS_OUTPUT} dev_state_e;
  typedef enum logic [1:0] {HS_IDLE, HS_WAIT, HS_XFER, HS_END} host_state_e;
endpackage
`default_nettype wire

/* adc_serial_readout_modes_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_readout_modes_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // link signals
  input wire logic cs_n,
  input wire logic dev_sck_oe,
  input wire logic dev_pullup,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe,
  input wire logic sck
);
  // ********************
  // frame rise counter
  // ********************
  logic       sck_q, sck_d;
  logic [4:0] rises_q, rises_d;

  // count clock rises while selected
  always_comb begin
    sck_d   = sck;
    rises_d = cs_n ? 5'h0 : rises_q + {4'h0, sck & ~sck_q};
  end

  // register the counter
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sck_q   <= 1'h1;
      rises_q <= 5'h0;
    end else begin
      sck_q   <= sck_d;
      rises_q <= rises_d;
    end
  end

  // ********************
  // link properties
  // ********************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  // clock phases and the busy flag after a frame
  sequence low_phase;  !sck [*4] ##1 sck; endsequence
  sequence high_phase; sck [*4] ##1 !sck; endsequence
  sequence busy_soon;  ##[1:8] dev_sdo_o; endsequence

  sdo_float_a: assert property (cs_n |=> !dev_sdo_oe)
    else $error("data driven while deselected");
  sdo_drive_a: assert property (!cs_n |=> dev_sdo_oe)
    else $error("data not driven while selected");
  ext_pick_a: assert property ($fell(cs_n) && !sck |=> !dev_sck_oe [*4])
    else $error("clock driven in external mode");
  int_pick_a: assert property ($fell(cs_n) && sck |-> ##[1:2] (dev_sck_oe && !sck))
    else $error("clock not pulled low in internal mode");
  pullup_off_a: assert property (!sck [*3] |-> !dev_pullup)
    else $error("pull-up on while clock low");
  frame_len_a: assert property (rises_q <= 5'h13)
    else $error("more than nineteen rises in a frame");
  int_low_a: assert property ($fell(sck) && dev_sck_oe && $past(dev_sck_oe) |-> low_phase)
    else $error("internal clock low phase wrong");
  int_high_a: assert property ($rose(sck) && dev_sck_oe && rises_q < 5'h12 |-> high_phase)
    else $error("internal clock high phase wrong");
  int_hold_a: assert property (dev_sck_oe && rises_q == 5'h13 |-> sck)
    else $error("clock not held high after frame");
  data_stable_a: assert property (!cs_n && $rose(sck) && rises_q < 5'h12 |=> $stable(dev_sdo_o) [*3])
    else $error("data moved near a rising edge");
  ext_busy_a: assert property (!cs_n && !dev_sck_oe && rises_q == 5'h13 && $fell(sck) |-> busy_soon)
    else $error("no busy flag after external frame");
  int_busy_a: assert property (dev_sck_oe && $rose(sck) && rises_q == 5'h12 |-> busy_soon)
    else $error("no busy flag after internal frame");
endmodule // adc_serial_readout_modes_asserts
`default_nettype wire

/* sck_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module sck_gen #(
  parameter int DIV = adc_pkg::SCK_DIV
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // control
  input  wire logic i_run,
  // clock level and edge events
  output logic      o_level,
  output logic      o_rise,
  output logic      o_fall
);
  import adc_pkg::*;
  localparam int HALF = DIV / 2;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       level_q;
  logic       level_d;
  logic       tick;

  // toggle every half period; first rise comes at once on run
  always_comb begin
    tick    = (cnt_q == 8'(HALF - 1));
    cnt_d   = cnt_q + 8'h01;
    level_d = level_q;
    if (!i_run) begin
      cnt_d   = 8'(HALF - 1);
      level_d = 1'h0;
    end else if (tick) begin
      cnt_d   = 8'h00;
      level_d = !level_q;
    end
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_q   <= 8'(HALF - 1);
      level_q <= 1'h0;
    end else begin
      cnt_q   <= cnt_d;
      level_q <= level_d;
    end
  end

  // edge events one cycle ahead of the level
  assign o_level = level_q;
  assign o_rise  = i_run & tick & !level_q;
  assign o_fall  = i_run & tick & level_q;
endmodule // sck_gen
`default_nettype wire

/* tb_adc_serial_readout_modes.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_adc_serial_readout_modes;
  import adc_pkg::*;
  // ********************
  // design under test
  // ********************
  localparam int POR_N  = 20;
  localparam int CONV_N = 200;
  localparam int TEST_N = 20;
  localparam logic [RESULT_BITS-1:0] VAL_A = 18'h2_5a3c;
  localparam logic [RESULT_BITS-1:0] VAL_B = 18'h1_c3a5;
  localparam logic [RESULT_BITS-1:0] VAL_C = 18'h3_0ff1;

  logic                   i_clk, i_srst, ext_mode, start, busy, valid;
  logic [RESULT_BITS-1:0] result, data;
  logic                   ext_a, sleep_a, ext_b, sleep_b, conv_b;
  int                     miscompares, comparisons, waited;

  adc_link_if lnk_a ();
  adc_link_if lnk_b ();

  // device and host facing each other, second device driven by hand
  adc_device #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N), .TEST_CYCLES(TEST_N)) i_adc_device (
    .i_clk(i_clk), .i_srst(i_srst), .link(lnk_a), .i_result(result),
    .o_ext_mode(ext_a), .o_sleeping(sleep_a), .o_conv_start());
  adc_host i_adc_host (.i_clk(i_clk), .i_srst(i_srst), .link(lnk_a), .i_ext_mode(ext_mode),
    .i_start(start), .o_busy(busy), .o_data(data), .o_valid(valid));
  adc_device #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N), .TEST_CYCLES(TEST_N)) i_adc_device_b (
    .i_clk(i_clk), .i_srst(i_srst), .link(lnk_b), .i_result(result),
    .o_ext_mode(ext_b), .o_sleeping(sleep_b), .o_conv_start(conv_b));
  adc_serial_readout_modes_asserts i_asserts (.i_clk(i_clk), .i_srst(i_srst), .cs_n(lnk_a.cs_n),
    .dev_sck_oe(lnk_a.dev_sck_oe), .dev_pullup(lnk_a.dev_pullup), .dev_sdo_o(lnk_a.dev_sdo_o),
    .dev_sdo_oe(lnk_a.dev_sdo_oe), .sck(lnk_a.sck));

  // 25 MHz clock
  initial begin
    i_clk = 1'h0;
    forever #20 i_clk = ~i_clk;
  end

  // ********************
  // helpers
  // ********************
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [RESULT_BITS-1:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, got);
    check(what, {17'h0, exp}, {17'h0, got});
  endtask

  function automatic logic level_of(input int which);
    case (which)
      0: level_of = valid;
      1: level_of = sleep_a;
      2: level_of = sleep_b;
      3: level_of = conv_b;
      4: level_of = lnk_b.sck;
      default: level_of = ~lnk_b.sck;
    endcase
  endfunction

  // bounded wait for a level, a timeout ends the run
  task automatic wait_on(input string what, input int which, input int lim);
    waited = 0;
    while (level_of(which) !== 1'h1 && waited < lim) begin
      tick(1);
      waited++;
    end
    if (waited >= lim) begin
      miscompares++;
      $display("CHECK FAILED %s expected 1 seen %b", what, level_of(which));
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one host read, judged against the expected word and mode
  task automatic host_read(input logic [RESULT_BITS-1:0] exp, input logic mode);
    start = 1'h1;
    tick(1);
    start = 1'h0;
    chk1("busy", 1'h1, busy);
    wait_on("valid", 0, 2000);
    check("data", exp, data);
    chk1("mode", mode, ext_a);
  endtask

  // ********************
  // scenarios
  // ********************
  task automatic int_read();
    wait_on("sleep a", 1, 600);
    result = VAL_B;
    host_read(VAL_A, 1'h0);
    chk1("converting", 1'h0, sleep_a);
    host_read(VAL_B, 1'h0);
  endtask

  task automatic ext_reads();
    ext_mode = 1'h1;
    wait_on("sleep a", 1, 600);
    result = VAL_C;
    host_read(VAL_B, 1'h1);
    host_read(VAL_C, 1'h1);
  endtask

  task automatic poll_resleep();
    wait_on("sleep b", 2, 600);
    lnk_b.cs_n = 1'h0;
    tick(3);
    chk1("poll clock", 1'h0, lnk_b.sck);
    chk1("poll status", 1'h0, lnk_b.sdo);
    chk1("poll mode", 1'h0, ext_b);
    chk1("poll awake", 1'h0, sleep_b);
    lnk_b.cs_n = 1'h1;
    tick(4);
    chk1("resleep", 1'h1, sleep_b);
    chk1("pullup back", 1'h1, lnk_b.dev_pullup);
    chk1("sdo float", 1'h0, lnk_b.dev_sdo_oe);
  endtask

  task automatic int_abort();
    lnk_b.cs_n = 1'h0;
    tick(2);
    wait_on("first rise", 4, 200);
    chk1("test delay", 1'h1, waited >= TEST_N - 2 && waited <= TEST_N + 2);
    wait_on("first fall", 5, 10);
    tick(1);
    lnk_b.cs_n = 1'h1;
    wait_on("abort start", 3, 8);
    tick(3);
    chk1("clock stays low", 1'h0, lnk_b.sck);
    chk1("pullup stays off", 1'h0, lnk_b.dev_pullup);
    wait_on("sleep b", 2, 600);
    lnk_b.cs_n = 1'h0;
    tick(4);
    chk1("external now", 1'h1, ext_b);
    lnk_b.host_sck_oe = 1'h1;
  endtask

  task automatic ext_abort();
    logic [2:0] bits;
    for (int k = 0; k < 3; k++) begin
      tick(4);
      bits[2-k] = lnk_b.sdo;
      lnk_b.host_sck_o = 1'h1;
      tick(4);
      lnk_b.host_sck_o = 1'h0;
    end
    check("first bits", {15'h0, 1'h0, VAL_C[17:16]}, {15'h0, bits});
    lnk_b.cs_n = 1'h1;
    wait_on("abort start", 3, 8);
    tick(2);
    chk1("sdo float", 1'h0, lnk_b.dev_sdo_oe);
  endtask

  // reset, then every scenario in turn
  initial begin
    i_srst = 1'h1;
    ext_mode = 1'h0;
    start = 1'h0;
    result = VAL_A;
    lnk_b.cs_n = 1'h1;
    lnk_b.host_sck_o = 1'h0;
    lnk_b.host_sck_oe = 1'h0;
    miscompares = 0;
    comparisons = 0;
    tick(10);
    i_srst = 1'h0;
    int_read();
    ext_reads();
    poll_resleep();
    int_abort();
    ext_abort();
    tally_and_finish();
  end
endmodule // tb_adc_serial_readout_modes
`default_nettype wire
